// ### include/idsf_det_if.sv
`timescale 1ns/10ps
interface idsf_det_if;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic sda_val;
  modport det
  (
    output start_det,
    output stop_det,
    output scl_rise,
    output scl_fall,
    output sda_val
  );
  modport core
  (
    input start_det,
    input stop_det,
    input scl_rise,
    input scl_fall,
    input sda_val
  );
endinterface

// ### include/idsf_pkg.sv
package idsf_pkg;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] adr_ctrl = 4'h0;
  localparam logic [3:0] adr_stat = 4'h1;
  localparam logic [3:0] adr_irq_stat = 4'h2;
  localparam logic [3:0] adr_irq_mask = 4'h3;
  localparam logic [3:0] adr_tx_data = 4'h4;
  localparam logic [3:0] adr_rx_data = 4'h5;
  // ****************************************************************
  // Control register field positions
  // ****************************************************************
  localparam int ctrl_start_pos = 0;
  localparam int ctrl_stop_pos = 1;
  localparam int ctrl_ack_pos = 2;
  localparam int ctrl_master_pos = 3;
  localparam int ctrl_wait_release_bit_pos = 5;
  localparam int ctrl_communication_release_bit_pos = 6;
  localparam int ctrl_ien_pos = 7;
  localparam logic [7:0] ctrl_reset = 8'h00;
  // ****************************************************************
  // Interrupt bit positions
  // ****************************************************************
  localparam int irq_byte_pos = 0;
  localparam int irq_stop_pos = 1;
  localparam int irq_arb_pos = 2;
  localparam int irq_start_pos = 3;
  localparam int irq_width = 4;
  // ****************************************************************
  // Timing: half bit period
  // ****************************************************************
  localparam int clk_mhz = 20;
  localparam int half_bit_ns = 5000;
  localparam int half_bit_cyc = (half_bit_ns * clk_mhz) / 1000;
  localparam int ninth_bit = 9;
endpackage

// ### tb/idsf_peer.sv
`timescale 1ns/10ps
module idsf_peer
#(
  parameter int hc = 8
)
(
  input wire logic mclk,
  input wire logic scl,
  output logic scl_oe,
  output logic sda_oe
);
  // ************************************************
  // Remote master on the two-wire bus
  // ************************************************
  logic stuck = 1'b0;
  int n;
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Release clock, bounded wait for high, then high time
  task automatic up();
    scl_oe <= 1'b0;
    for (n = 0; n < 900 && !scl; n++)
      @(posedge mclk);
    if (!scl)
      stuck = 1'b1;
    repeat (hc) @(posedge mclk);
  endtask
  // Start or repeated start
  task automatic start();
    sda_oe <= 1'b0;
    repeat (hc) @(posedge mclk);
    up();
    sda_oe <= 1'b1;
    repeat (hc) @(posedge mclk);
    scl_oe <= 1'b1;
    repeat (hc) @(posedge mclk);
  endtask
  // Bits out, first byte last bit is direction
  task automatic bits(input logic [7:0] b, input int k);
    for (int i = 0; i < k; i++)
    begin
      sda_oe <= i < 8 && !b[7 - i];
      repeat (hc) @(posedge mclk);
      up();
      scl_oe <= 1'b1;
      repeat (2) @(posedge mclk);
    end
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    sda_oe <= 1'b1;
    repeat (hc) @(posedge mclk);
    up();
    sda_oe <= 1'b0;
    repeat (hc) @(posedge mclk);
  endtask
  // Hold data low to win arbitration
  task automatic hold(input logic v);
    sda_oe <= v;
  endtask
endmodule

// ### tb/idsf_top_chk.sv
`timescale 1ns/10ps
module idsf_chk
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe
);
  // ************************************************
  // Bus idle tracking
  // ************************************************
  logic [3:0] idle;
  logic sda_q;
  logic rs;
  logic wc;
  // Status read and control write strobes
  assign rs = rd && addr == idsf_pkg::adr_stat;
  assign wc = wr && addr == idsf_pkg::adr_ctrl;
  // Cycles since a stop, zeroed by any start
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idle <= 4'hf;
      sda_q <= 1'b1;
    end
    else
    begin
      sda_q <= sda_i;
      if ((wc && wdata[0]) || (scl_i && sda_q && !sda_i))
        idle <= 4'h0;
      else if (scl_i && !sda_q && sda_i)
        idle <= 4'h1;
      else if (idle != 4'h0 && idle != 4'hf)
        idle <= idle + 4'h1;
    end
  end
  // ************************************************
  // Assertions
  // ************************************************
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property (
    $rose(rst_n) |-> !sda_oe && !scl_oe && !irq)
    else $error("outputs active after reset");
  a_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_read: assert property (rd && addr > 4'h5 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mask_off: assert property (
    wr && addr == idsf_pkg::adr_irq_mask && wdata == 8'h00 |=> !irq)
    else $error("masked interrupt still high");
  a_release_clear: assert property (
    wc && wdata[6] ##2 rs |=> !rdata[0])
    else $error("flag kept after release");
  a_enable_fall: assert property (
    wc && !wdata[7] ##2 rs |=> !rdata[0])
    else $error("flag kept after disable");
  a_stop_clear: assert property (
    rs && idle > 4'h5 |=> !rdata[0])
    else $error("flag set after stop");
  a_start_set: assert property (
    wc && wdata == 8'h89 && idle > 4'h5 ##1 rs |=> rdata[0])
    else $error("flag clear after start");
  c_flag_set: cover property (rs ##1 rdata[0]);
  c_arb_lost: cover property (rs ##1 rdata[1]);
  c_irq_drop: cover property (irq ##1 !irq);
endmodule
bind idsf_top idsf_chk i_chk
(
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .irq(irq), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  // ************************************************
  // Clock, wiring and instances
  // ************************************************
  localparam logic [3:0] c_ctl = idsf_pkg::adr_ctrl;
  localparam logic [3:0] c_st = idsf_pkg::adr_stat;
  localparam logic [3:0] c_is = idsf_pkg::adr_irq_stat;
  localparam logic [3:0] c_im = idsf_pkg::adr_irq_mask;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic irq, scl_o, scl_oe, sda_o, sda_oe, p_scl_oe, p_sda_oe;
  int fail_count = 0;
  int check_count = 0;
  // Pulled-up open-drain lines
  wire scl = !(scl_oe || p_scl_oe);
  wire sda = !(sda_oe || p_sda_oe);
  always #25 mclk = !mclk;
  idsf_top #(.half_cyc(4)) i_dut
  (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe)
  );
  idsf_peer #(.hc(8)) i_peer
  (
    .mclk(mclk), .scl(scl), .scl_oe(p_scl_oe), .sda_oe(p_sda_oe)
  );
  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rbit(input logic [3:0] a, input int b, input logic e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    rv = rdata;
    @(posedge mclk);
    if (b < 8)
      chk({7'h00, rv[b]}, {7'h00, e});
  endtask
  // Pin level check: 0 interrupt, 1 data drive
  task automatic pin(input int sel, input logic e);
    @(negedge mclk);
    chk({7'h00, sel ? sda_oe : irq}, {7'h00, e});
    @(posedge mclk);
  endtask
  // Bounded poll of a status bit
  task automatic poll(input int b, input logic v);
    int i;
    for (i = 0; i < 80; i++)
    begin
      rbit(c_st, 8, 1'b0);
      if (rv[b] === v)
        break;
    end
    chk({7'h00, rv[b]}, {7'h00, v});
    if (i == 80)
      test_done();
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    pin(1, 1'b0);
    rbit(c_st, 0, 1'b0);
  endtask
  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_irq();
    wreg(c_ctl, 8'h80);
    @(posedge mclk);
    wreg(c_im, 8'h08);
    i_peer.start();
    pin(0, 1'b1);
    rbit(c_is, 3, 1'b1);
    wreg(c_im, 8'h00);
    pin(0, 1'b0);
    wreg(c_im, 8'h08);
    pin(0, 1'b1);
    wreg(c_is, 8'h08);
    pin(0, 1'b0);
    i_peer.stop();
  endtask
  // Slave set, repeated start, stop
  task automatic t_slave();
    i_peer.start();
    i_peer.bits(8'h81, 8);
    poll(0, 1'b1);
    i_peer.start();
    poll(0, 1'b0);
    i_peer.bits(8'h80, 8);
    rbit(c_st, 0, 1'b0);
    i_peer.start();
    i_peer.bits(8'h81, 8);
    poll(0, 1'b1);
    i_peer.stop();
    poll(0, 1'b0);
    rbit(c_is, 1, 1'b1);
  endtask
  // Software clear while flag set
  task automatic t_clear(input logic [7:0] c);
    i_peer.start();
    i_peer.bits(8'h81, 8);
    poll(0, 1'b1);
    wreg(c_ctl, c);
    @(posedge mclk);
    rbit(c_st, 0, 1'b0);
    pin(1, 1'b0);
    i_peer.stop();
    wreg(c_ctl, 8'h80);
  endtask
  task automatic t_wait_release_bit();
    wreg(idsf_pkg::adr_tx_data, 8'h00);
    i_peer.start();
    i_peer.bits(8'h81, 9);
    poll(3, 1'b1);
    pin(1, 1'b1);
    wreg(c_ctl, 8'ha0);
    rbit(c_st, 0, 1'b0);
    pin(1, 1'b0);
    i_peer.stop();
  endtask
  // Master start with given first byte
  task automatic t_mstart(input logic [7:0] tx);
    do_reset();
    wreg(idsf_pkg::adr_tx_data, tx);
    @(posedge mclk);
    wreg(c_ctl, 8'h88);
    @(posedge mclk);
    wreg(c_ctl, 8'h89);
    rbit(c_st, 0, 1'b1);
  endtask
  task automatic t_arb();
    t_mstart(8'hff);
    for (int i = 0; i < 60 && !scl_oe; i++)
      @(negedge mclk);
    chk({7'h00, scl_oe}, 8'h01);
    @(posedge mclk);
    i_peer.hold(1'b1);
    poll(1, 1'b1);
    rbit(c_st, 0, 1'b0);
    i_peer.hold(1'b0);
    do_reset();
  endtask
  initial
  begin
    do_reset();
    rbit(4'hf, 8, 1'b0);
    chk(rv, 8'h00);
    t_irq();
    t_slave();
    t_clear(8'hc0);
    t_clear(8'h00);
    t_wait_release_bit();
    t_mstart(8'h01);
    poll(0, 1'b0);
    t_arb();
    chk({7'h00, i_peer.stuck}, 8'h00);
    test_done();
  end
endmodule

// ### verilog/idsf_cond_det.sv
`timescale 1ns/10ps
module idsf_cond_det
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  idsf_det_if.det det
);
  logic scl_q;
  logic sda_q;
  // ****************************************************************
  // Previous line levels
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end
  // Edge and condition decode
  assign det.start_det = scl_i & scl_q & sda_q & ~sda_i;
  assign det.stop_det = scl_i & scl_q & ~sda_q & sda_i;
  assign det.scl_rise = scl_i & ~scl_q;
  assign det.scl_fall = ~scl_i & scl_q;
  assign det.sda_val = sda_i;
endmodule

// ### verilog/idsf_top.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
// Contract
// (RULE_01) Flag 0: receive status, data line left high impedance. The code still drives it low through gen_sda_low while generating a stop.
// (RULE_02) Flag 1: transmit, shift latch drives data from ninth clock edge.
// (RULE_03) Stop condition detected clears the flag.
// (RULE_04) Writing one to release bit 6 of control clears the flag.
// (RULE_05) Interface enable falling from one to zero clears the flag.
// (RULE_06) Arbitration lost rising from zero to one clears the flag.
// (RULE_07) Wait release at ninth clock clears flag, then releases data line.
// (RULE_08) Master sending direction bit one clears the flag.
// (RULE_09) Slave detecting start condition clears the flag.
// (RULE_10) Master generating start condition sets the flag.
// (RULE_11) Slave receiving direction bit one in first byte sets the flag.
// (RULE_12) Reset forces flag to zero, data line high impedance.
module idsf_top
#(
  parameter int half_cyc = idsf_pkg::half_bit_cyc
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // Elaboration check of the half bit count
  if (half_cyc < 2 || half_cyc > 65535)
  begin : g_half_chk
    $error("half_cyc out of range");
  end

  typedef enum logic [2:0] {idsf_idle, idsf_start, idsf_low, idsf_high,
    idsf_stop_a, idsf_stop_b} idsf_state_t;

  idsf_det_if det_bus();
  idsf_cond_det u_det
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .det(det_bus)
  );

  logic [7:0] ctrl;
  logic direction_status_flag;
  logic arbitration_lost_flag;
  localparam int irq_w = idsf_pkg::irq_width;
  logic [irq_w-1:0] irq_stat;
  logic [irq_w-1:0] irq_mask;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic first_byte;
  logic busy;
  logic wait_hold;
  logic so_latch;
  logic master_drive;
  logic ien_q;
  logic [15:0] tmr;
  idsf_state_t state;

  // ****************************************************************
  // Control decode
  // ****************************************************************
  logic wr_ctrl;
  logic communication_release_bit_wr;
  logic wait_release_bit_wr;
  logic ien;
  logic is_master;
  logic ien_fall;
  logic arb_set;
  logic arb_rise;
  logic gen_start;
  logic gen_stop;
  logic tmr_done;
  logic ninth_rise;
  logic byte_done;
  logic dir_bit_one;
  assign wr_ctrl = wr && addr == idsf_pkg::adr_ctrl;
  assign communication_release_bit_wr = wr_ctrl && wdata[idsf_pkg::ctrl_communication_release_bit_pos];
  assign wait_release_bit_wr = wr_ctrl && wdata[idsf_pkg::ctrl_wait_release_bit_pos];
  assign ien = ctrl[idsf_pkg::ctrl_ien_pos];
  assign is_master = ctrl[idsf_pkg::ctrl_master_pos];
  assign ien_fall = ien_q && !ien;
  assign gen_start = wr_ctrl && wdata[idsf_pkg::ctrl_start_pos] && ien
    && is_master && !busy;
  assign gen_stop = wr_ctrl && wdata[idsf_pkg::ctrl_stop_pos] && ien
    && is_master;
  assign tmr_done = tmr == 16'h0000;
  // Rises counted from zero: the eighth sees 7, the ninth sees 8
  assign ninth_rise = det_bus.scl_rise
    && bit_cnt == 4'(idsf_pkg::ninth_bit - 1);
  assign byte_done = det_bus.scl_rise && bit_cnt == 4'h7;
  assign dir_bit_one = byte_done && first_byte && det_bus.sda_val;
  // Master loses arbitration when it sends one but sees zero
  assign arb_set = det_bus.scl_rise && is_master && bit_cnt < 4'h8
    && so_latch && !det_bus.sda_val && direction_status_flag;
  assign arb_rise = arb_set && !arbitration_lost_flag;

  // Control register, one-shot bits self clear
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= idsf_pkg::ctrl_reset;
    else if (wr_ctrl)
      ctrl <= wdata & 8'h8c;
  end

  // Enable history for falling edge detection
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ien_q <= 1'b0;
    else
      ien_q <= ien;
  end

  // ****************************************************************
  // Direction status flag
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      direction_status_flag <= 1'b0; // RULE_12
    else if (gen_start)
      direction_status_flag <= 1'b1; // RULE_10
    else if (!is_master && dir_bit_one)
      direction_status_flag <= 1'b1; // RULE_11
    else if (det_bus.stop_det)
      direction_status_flag <= 1'b0; // RULE_03
    else if (communication_release_bit_wr)
      direction_status_flag <= 1'b0; // RULE_04
    else if (ien_fall)
      direction_status_flag <= 1'b0; // RULE_05
    else if (arb_rise)
      direction_status_flag <= 1'b0; // RULE_06
    else if (wait_release_bit_wr && wait_hold)
      direction_status_flag <= 1'b0; // RULE_07
    else if (is_master && byte_done && first_byte && tx_data[0])
      direction_status_flag <= 1'b0; // RULE_08
    else if (!is_master && det_bus.start_det)
      direction_status_flag <= 1'b0; // RULE_09
  end

  // Arbitration lost flag, cleared by start or release
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      arbitration_lost_flag <= 1'b0;
    else if (arb_set)
      arbitration_lost_flag <= 1'b1;
    else if (communication_release_bit_wr || gen_start)
      arbitration_lost_flag <= 1'b0;
  end

  // ****************************************************************
  // Bus shifter
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt <= 4'h0;
      first_byte <= 1'b0;
      busy <= 1'b0;
      wait_hold <= 1'b0;
      shift <= 8'h00;
      rx_data <= 8'h00;
    end
    else if (det_bus.start_det || gen_start)
    begin
      bit_cnt <= 4'h0;
      first_byte <= 1'b1;
      busy <= 1'b1;
      wait_hold <= 1'b0;
      shift <= 8'h00;
    end
    else if (det_bus.stop_det || communication_release_bit_wr || !ien)
    begin
      bit_cnt <= 4'h0;
      first_byte <= 1'b0;
      busy <= 1'b0;
      wait_hold <= 1'b0;
    end
    else if (busy && det_bus.scl_rise)
    begin
      if (bit_cnt < 4'h8)
      begin
        shift <= {shift[6:0], det_bus.sda_val};
        bit_cnt <= bit_cnt + 4'h1;
      end
      else
      begin
        rx_data <= shift;
        bit_cnt <= 4'h9;
        wait_hold <= 1'b1;
      end
    end
    else if (wait_release_bit_wr && wait_hold)
    begin
      bit_cnt <= 4'h0;
      first_byte <= 1'b0;
      wait_hold <= 1'b0;
    end
  end

  // Transmit data register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tx_data <= 8'h00;
    else if (wr && addr == idsf_pkg::adr_tx_data)
      tx_data <= wdata;
  end

  // Shift output latch: next bit on falling clock
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      so_latch <= 1'b1;
    else if (det_bus.scl_fall && bit_cnt < 4'h8)
      so_latch <= tx_data[3'(7 - 32'(bit_cnt))];
    else if (det_bus.scl_fall && bit_cnt == 4'h8)
      so_latch <= !ctrl[idsf_pkg::ctrl_ack_pos];
    else if (det_bus.scl_fall)
      so_latch <= tx_data[7]; // First bit after the ninth clock
  end

  // Output drive window, opens at the ninth clock rising edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      master_drive <= 1'b0;
    else if (!direction_status_flag)
      master_drive <= 1'b0; // RULE_01
    else if (ninth_rise && first_byte)
      master_drive <= 1'b1; // RULE_02
  end

  // ****************************************************************
  // Master clock and condition generator
  // ****************************************************************
  logic gen_sda_low;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= idsf_idle;
      tmr <= 16'h0000;
      gen_sda_low <= 1'b0;
      scl_oe <= 1'b0;
    end
    else if (!ien || arb_set)
    begin
      state <= idsf_idle;
      gen_sda_low <= 1'b0;
      scl_oe <= 1'b0;
    end
    else if (gen_stop)
    begin
      state <= idsf_stop_a;
      tmr <= 16'(half_cyc);
      gen_sda_low <= 1'b1;
    end
    else if (gen_start)
    begin
      state <= idsf_start;
      tmr <= 16'(half_cyc);
      gen_sda_low <= 1'b1;
    end
    else if (!tmr_done)
      tmr <= tmr - 16'h0001;
    else
    begin
      tmr <= 16'(half_cyc);
      case (state)
        idsf_idle:
          state <= idsf_idle;
        idsf_start:
        begin
          gen_sda_low <= 1'b0;
          scl_oe <= 1'b1;
          state <= idsf_low;
        end
        idsf_low:
        begin
          if (!wait_hold)
          begin
            scl_oe <= 1'b0;
            state <= idsf_high;
          end
        end
        idsf_high:
        begin
          scl_oe <= 1'b1;
          state <= idsf_low;
        end
        idsf_stop_a:
        begin
          scl_oe <= 1'b0;
          state <= idsf_stop_b;
        end
        idsf_stop_b:
        begin
          gen_sda_low <= 1'b0;
          state <= idsf_idle;
        end
        default:
          state <= idsf_idle;
      endcase
    end
  end
  assign scl_o = 1'b0;

  // ****************************************************************
  // Data line drive
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sda_oe <= 1'b0; // RULE_12
    else if (gen_sda_low)
      sda_oe <= 1'b1;
    else if (!direction_status_flag || !(master_drive || is_master))
      sda_oe <= 1'b0; // RULE_01 RULE_07
    else
      sda_oe <= !so_latch; // RULE_02
  end
  assign sda_o = 1'b0;

  // ****************************************************************
  // Interrupts, write one to clear, set wins
  // ****************************************************************
  logic [irq_w-1:0] irq_ev;
  always_comb
  begin
    irq_ev = '0;
    irq_ev[idsf_pkg::irq_byte_pos] = busy && byte_done;
    irq_ev[idsf_pkg::irq_stop_pos] = det_bus.stop_det;
    irq_ev[idsf_pkg::irq_arb_pos] = arb_rise;
    irq_ev[idsf_pkg::irq_start_pos] = det_bus.start_det;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat <= '0;
    else if (wr && addr == idsf_pkg::adr_irq_stat)
      irq_stat <= (irq_stat & ~wdata[irq_w-1:0]) | irq_ev;
    else
      irq_stat <= irq_stat | irq_ev;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask <= '0;
    else if (wr && addr == idsf_pkg::adr_irq_mask)
      irq_mask <= wdata[irq_w-1:0];
  end
  assign irq = |(irq_stat & irq_mask);

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        idsf_pkg::adr_ctrl: rdata <= ctrl;
        idsf_pkg::adr_stat: rdata <= {4'h0, wait_hold, busy,
          arbitration_lost_flag, direction_status_flag};
        idsf_pkg::adr_irq_stat: rdata <= {4'h0, irq_stat};
        idsf_pkg::adr_irq_mask: rdata <= {4'h0, irq_mask};
        idsf_pkg::adr_tx_data: rdata <= tx_data;
        idsf_pkg::adr_rx_data: rdata <= rx_data;
        default: rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule
